/* File: pkg/pwr_avg_pkg.sv */
// shared constants and carrier types for the current/power averaging sequencer
package pwr_avg_pkg;
    localparam int ADC_W    = 12;
    localparam int CUR_W    = 16;
    localparam int PWR_W    = 24;
    localparam int CAL_W    = 16;
    localparam int ACC_W    = 36;
    localparam int CNT_W    = 11;
    localparam int CUR_SHIFT = 11;               // scaling shift of shunt*cal product
    localparam int PWR_SHIFT = 8;                // scaling shift of current*bus product

    // operating mode field
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_CONT   = 3'h7;

    // averaging count encodings -> sample counts
    localparam logic [CNT_W-1:0] AVG_ONE = 11'h001;

    typedef logic [CNT_W-1:0] avg_table_type [8];
    localparam avg_table_type AVG_TABLE = '{11'h001, 11'h004, 11'h010, 11'h040,
                                            11'h080, 11'h100, 11'h200, 11'h400};
    localparam logic [3:0] AVG_LOG2 [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};

    // configuration carrier
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] avg_sel;
        logic       shunt_only;
    } cfg_type;

    // converter request carrier
    typedef struct packed {
        logic start;
        logic sel_bus;
    } adc_req_type;

    // averaged result carrier
    typedef struct packed {
        logic [CUR_W-1:0] current;
        logic [PWR_W-1:0] power;
    } result_type;
endpackage

/* File: core/pwr_calc.sv */
// current and power multiply stage, one registered step
`timescale 1ns/1ns
module pwr_calc (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_ce,
    input  wire logic                          i_go,
    input  wire logic                          i_skip_bus,
    input  wire logic [pwr_avg_pkg::ADC_W-1:0] i_shunt,
    input  wire logic [pwr_avg_pkg::ADC_W-1:0] i_bus,
    input  wire logic [pwr_avg_pkg::CAL_W-1:0] i_cal,
    output logic                               o_done,
    output pwr_avg_pkg::result_type            o_res
);
    typedef struct packed {
        logic                    done;
        pwr_avg_pkg::result_type res;
    } calc_state_type;

    calc_state_type st_r;
    calc_state_type st_nxt;

    // current first, then power from that current and the newest bus sample
    always_comb begin
        logic [pwr_avg_pkg::ADC_W+pwr_avg_pkg::CAL_W-1:0] prod_i;
        logic [pwr_avg_pkg::CUR_W+pwr_avg_pkg::ADC_W-1:0] prod_p;
        logic [pwr_avg_pkg::CUR_W-1:0]                    cur;
        prod_i = {{pwr_avg_pkg::CAL_W{1'b0}}, i_shunt} * {{pwr_avg_pkg::ADC_W{1'b0}}, i_cal};
        cur    = pwr_avg_pkg::CUR_W'(prod_i >> pwr_avg_pkg::CUR_SHIFT);
        prod_p = {{pwr_avg_pkg::ADC_W{1'b0}}, cur} * {{pwr_avg_pkg::CUR_W{1'b0}}, i_bus};
        st_nxt = st_r;
        st_nxt.done = i_go;
        if (i_go) begin
            st_nxt.res.current = cur;
            // zero calibration or no bus sample forces zero power
            if (i_cal == '0 || i_skip_bus) begin
                st_nxt.res.power = '0;
            end else begin
                st_nxt.res.power = pwr_avg_pkg::PWR_W'(prod_p >> pwr_avg_pkg::PWR_SHIFT);
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_done = st_r.done;
    assign o_res  = st_r.res;
endmodule

/* File: core/pwr_avg_seq.sv */
// sequencer: converter multiplexing, averaging and result loading
`timescale 1ns/1ns
// How it works
// - one converter alternates shunt then bus channel
// - math starts after both samples complete, or after the shunt sample alone in shunt-only
// - power uses latest current and bus sample
// - zero calibration gives zero power
// - add each intermediate result into accumulators
// - load averages to outputs after last sample
// - math overlaps next conversion, never stalls
// - shunt-only option skips bus conversions
// - mode 111 converts continuously
// - mode 001 runs one set per write
// - ready flag sets at end, clears on read or on a write of any mode but off
module pwr_avg_seq (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_ce,
    input  wire pwr_avg_pkg::cfg_type          i_cfg,
    input  wire logic                          i_cfg_wr,
    input  wire logic [pwr_avg_pkg::CAL_W-1:0] i_cal,
    input  wire logic                          i_mask_rd,
    input  wire logic                          i_adc_done,
    input  wire logic [pwr_avg_pkg::ADC_W-1:0] i_adc_data,
    output pwr_avg_pkg::adc_req_type           o_adc_req,
    output pwr_avg_pkg::result_type            o_result,
    output logic                               o_conversion_ready_flag
);
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SHUNT = 4'b0010,
        S_BUS   = 4'b0100,
        S_DRAIN = 4'b1000
    } seq_state_type;

    typedef struct packed {
        seq_state_type                 fsm;
        pwr_avg_pkg::adc_req_type      req;
        logic [pwr_avg_pkg::ADC_W-1:0] shunt;
        logic [pwr_avg_pkg::ADC_W-1:0] bus;
        logic                          go;
        logic                          last;
        logic [pwr_avg_pkg::CNT_W-1:0] count;
        logic [pwr_avg_pkg::ACC_W-1:0] acc_i;
        logic [pwr_avg_pkg::ACC_W-1:0] acc_p;
        pwr_avg_pkg::result_type       result;
        logic                          rdy;
    } seq_reg_type;

    seq_reg_type st_r;
    seq_reg_type st_nxt;

    logic                    calc_done;
    pwr_avg_pkg::result_type calc_res;

    // multiply stage runs beside the converter, so it adds no conversion time
    pwr_calc u_calc (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_ce       (i_ce),
        .i_go       (st_r.go),
        .i_skip_bus (i_cfg.shunt_only),
        .i_shunt    (st_r.shunt),
        .i_bus      (st_r.bus),
        .i_cal      (i_cal),
        .o_done     (calc_done),
        .o_res      (calc_res)
    );

    // sequencing, accumulation and ready flag
    always_comb begin
        logic [pwr_avg_pkg::CNT_W-1:0] n;
        logic [3:0]                    sh;
        logic [pwr_avg_pkg::ACC_W-1:0] sum_i;
        logic [pwr_avg_pkg::ACC_W-1:0] sum_p;
        n      = pwr_avg_pkg::AVG_TABLE[i_cfg.avg_sel];
        sh     = pwr_avg_pkg::AVG_LOG2[i_cfg.avg_sel];
        st_nxt = st_r;
        st_nxt.req.start = 1'b0;
        st_nxt.go        = 1'b0;
        sum_i = st_r.acc_i + pwr_avg_pkg::ACC_W'(calc_res.current);
        sum_p = st_r.acc_p + pwr_avg_pkg::ACC_W'(calc_res.power);

        unique case (st_r.fsm)
            S_IDLE: begin
                // a single shot needs a fresh write, continuous needs none
                if ((i_cfg_wr && i_cfg.mode == pwr_avg_pkg::MODE_SINGLE) ||
                    i_cfg.mode == pwr_avg_pkg::MODE_CONT) begin
                    st_nxt.fsm         = S_SHUNT;
                    st_nxt.req.start   = 1'b1;
                    st_nxt.req.sel_bus = 1'b0;
                end
            end
            S_SHUNT: begin
                if (i_adc_done) begin
                    st_nxt.shunt = i_adc_data;
                    if (i_cfg.shunt_only) begin
                        st_nxt.go  = 1'b1;
                        st_nxt.fsm = S_DRAIN;
                    end else begin
                        st_nxt.fsm         = S_BUS;
                        st_nxt.req.start   = 1'b1;
                        st_nxt.req.sel_bus = 1'b1;
                    end
                end
            end
            S_BUS: begin
                if (i_adc_done) begin
                    st_nxt.bus = i_adc_data;
                    st_nxt.go  = 1'b1;
                    st_nxt.fsm = S_DRAIN;
                end
            end
            S_DRAIN: begin
                // sample counted now; next conversion starts while math finishes
                st_nxt.count = st_r.count + pwr_avg_pkg::AVG_ONE;
                st_nxt.last  = (st_r.count + pwr_avg_pkg::AVG_ONE) >= n;
                if ((st_r.count + pwr_avg_pkg::AVG_ONE) < n ||
                    i_cfg.mode == pwr_avg_pkg::MODE_CONT) begin
                    st_nxt.fsm         = S_SHUNT;
                    st_nxt.req.start   = 1'b1;
                    st_nxt.req.sel_bus = 1'b0;
                end else begin
                    st_nxt.fsm = S_IDLE;
                end
                if ((st_r.count + pwr_avg_pkg::AVG_ONE) >= n) begin
                    st_nxt.count = '0;
                end
            end
            default: st_nxt.fsm = S_IDLE;
        endcase

        // intermediate results pile up until the set is complete
        if (calc_done) begin
            if (st_r.last) begin
                st_nxt.result.current = pwr_avg_pkg::CUR_W'(sum_i >> sh);
                st_nxt.result.power   = pwr_avg_pkg::PWR_W'(sum_p >> sh);
                st_nxt.acc_i          = '0;
                st_nxt.acc_p          = '0;
            end else begin
                st_nxt.acc_i = sum_i;
                st_nxt.acc_p = sum_p;
            end
        end

        // clear first so that a completing set in the same cycle wins
        if ((i_cfg_wr && i_cfg.mode != pwr_avg_pkg::MODE_OFF) || i_mask_rd) begin
            st_nxt.rdy = 1'b0;
        end
        if (calc_done && st_r.last) begin
            st_nxt.rdy = 1'b1;
        end

        // a power-down write sends the sequence to idle on the next edge, dropping the conversion in flight
        if (i_cfg_wr && i_cfg.mode == pwr_avg_pkg::MODE_OFF) begin
            st_nxt.fsm   = S_IDLE;
            st_nxt.count = '0;
            st_nxt.acc_i = '0;
            st_nxt.acc_p = '0;
            st_nxt.req.start = 1'b0;
            // channel select only ever moves together with a start pulse
            st_nxt.req.sel_bus = st_r.req.sel_bus;
        end
    end

    // state register; the last flag is ready when the multiply stage ends
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_r <= '{fsm: S_IDLE, default: '0};
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_adc_req               = st_r.req;
    assign o_result                = st_r.result;
    assign o_conversion_ready_flag = st_r.rdy;
endmodule

/* File: verif/adc_model.sv */
// converter model: answers each start after a set delay
`timescale 1ns/1ns
module adc_model (
    input  wire logic                          i_core_clk,
    input  wire pwr_avg_pkg::adc_req_type      i_req,
    input  wire logic [3:0]                    i_dly,
    input  wire logic [pwr_avg_pkg::ADC_W-1:0] i_sh,
    input  wire logic [pwr_avg_pkg::ADC_W-1:0] i_bus,
    output logic                               o_done = 1'b0,
    output logic [pwr_avg_pkg::ADC_W-1:0]      o_data = 12'h000
);
    logic [3:0] cnt_r = 4'h0;
    logic       sel_r = 1'b0;
    // =====
    // data toggles outside done so a stale word never looks valid
    always @(posedge i_core_clk) begin
        if (!i_req.start && cnt_r == 4'h1) begin
            o_done <= 1'b1;
            o_data <= sel_r ? i_bus : i_sh;
        end else begin
            o_done <= 1'b0;
            o_data <= ~o_data;
        end
        if (i_req.start) begin
            cnt_r <= i_dly;
            sel_r <= i_req.sel_bus;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule

/* File: verif/pwr_avg_sva.sv */
// port assertions for the averaging sequencer
`timescale 1ns/1ns
module pwr_avg_sva (
    input wire logic                          i_core_clk,
    input wire logic                          i_rst_n,
    input wire logic                          i_ce,
    input wire pwr_avg_pkg::cfg_type          i_cfg,
    input wire logic                          i_cfg_wr,
    input wire logic [pwr_avg_pkg::CAL_W-1:0] i_cal,
    input wire logic                          i_mask_rd,
    input wire logic                          i_adc_done,
    input wire logic [pwr_avg_pkg::ADC_W-1:0] i_adc_data,
    input wire pwr_avg_pkg::adc_req_type      o_adc_req,
    input wire pwr_avg_pkg::result_type       o_result,
    input wire logic                          o_conversion_ready_flag
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // =====
    // sequencing, flag timing, enable freeze and zero-cal power
    AST_START_PULSE: assert property (o_adc_req.start && i_ce |=> !o_adc_req.start)
        else $error("start wider than one cycle");
    AST_SEL_HOLD: assert property (!o_adc_req.start |-> $stable(o_adc_req.sel_bus))
        else $error("channel moved without start");
    AST_BUS_NEXT: assert property (i_adc_done && !o_adc_req.sel_bus && !i_cfg.shunt_only && !i_cfg_wr
        && i_cfg.mode != pwr_avg_pkg::MODE_OFF |=> o_adc_req.start && o_adc_req.sel_bus)
        else $error("bus start missing after shunt");
    AST_CONT_NEXT: assert property (i_adc_done && o_adc_req.sel_bus && !i_cfg_wr
        && i_cfg.mode == pwr_avg_pkg::MODE_CONT ##1 !i_cfg_wr |-> ##1 o_adc_req.start && !o_adc_req.sel_bus)
        else $error("continuous shunt start late");
    AST_SKIP_BUS: assert property (i_cfg.shunt_only |-> !(o_adc_req.start && o_adc_req.sel_bus))
        else $error("bus conversion in shunt-only");
    AST_FLAG_LAT: assert property ($rose(o_conversion_ready_flag) |-> $past(i_adc_done, 3))
        else $error("flag rose off schedule");
    AST_RES_END: assert property ($changed(o_result) |-> o_conversion_ready_flag && $past(i_adc_done, 3))
        else $error("result changed off set end");
    AST_RD_CLR: assert property (i_mask_rd && i_ce && !$past(i_adc_done, 2) |=> !o_conversion_ready_flag)
        else $error("flag kept after read");
    AST_CE_FREEZE: assert property (!i_ce |=> $stable(o_adc_req) && $stable(o_result)
        && $stable(o_conversion_ready_flag))
        else $error("outputs moved while enable low");
    AST_ZERO_CAL: assert property ($changed(o_result) && i_cal == '0 |-> o_result.power == '0)
        else $error("power nonzero with zero cal");
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the averaging sequencer
`timescale 1ns/1ns
module tb_top;
    logic                          clk = 1'b0;
    logic                          rst_n = 1'b0;
    logic                          ce = 1'b1;
    pwr_avg_pkg::cfg_type          cfg = '0;
    logic                          wr = 1'b0;
    logic                          rd = 1'b0;
    logic [15:0]                   cal = 16'h1000;
    logic [3:0]                    dly = 4'h3;
    logic [11:0]                   sh = 12'h123;
    logic [11:0]                   bus = 12'h456;
    logic                          done;
    logic [11:0]                   data;
    pwr_avg_pkg::adc_req_type      req;
    pwr_avg_pkg::result_type       res;
    logic                          flag;
    int                            err_count = 0;
    int                            samples_checked = 0;
    int                            n_sh = 0;
    int                            n_bus = 0;
    pwr_avg_seq dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cfg(cfg), .i_cfg_wr(wr), .i_cal(cal),
        .i_mask_rd(rd), .i_adc_done(done), .i_adc_data(data), .o_adc_req(req), .o_result(res),
        .o_conversion_ready_flag(flag));
    adc_model adc (.i_core_clk(clk), .i_req(req), .i_dly(dly), .i_sh(sh), .i_bus(bus), .o_done(done),
        .o_data(data));
    // =====
    initial forever #5 clk = ~clk;
    // count starts per channel
    always @(posedge clk) begin
        if (req.start === 1'b1) begin
            if (req.sel_bus) n_bus <= n_bus + 1;
            else n_sh <= n_sh + 1;
        end
    end
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // write the config, clear counts; returns after the first start edge
    task automatic wcfg(input logic [2:0] m, input logic [2:0] a, input logic s);
        cfg <= '{mode: m, avg_sel: a, shunt_only: s};
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        n_sh = 0;
        n_bus = 0;
        @(posedge clk);
    endtask
    // power is zero for zero cal or shunt-only, as averages of equal samples
    task automatic wait_res(input logic s);
        logic [15:0] c;
        c = 16'((32'(sh) * 32'(cal)) >> pwr_avg_pkg::CUR_SHIFT);
        for (int i = 0; i < 30000 && flag !== 1'b1; i++) @(posedge clk);
        check(40'(flag), 40'h1);
        check(res, {c, (s || cal == 0) ? 24'h0 : 24'((40'(c) * 40'(bus)) >> pwr_avg_pkg::PWR_SHIFT)});
    endtask
    task automatic t_avg_all();
        for (int a = 0; a < 8; a++) begin
            dly <= (a % 2) ? 4'h9 : 4'h3;
            wcfg(pwr_avg_pkg::MODE_SINGLE, 3'(a), 1'b0);
            check(40'(flag), 40'h0);
            wait_res(1'b0);
            check(40'(n_sh), 40'(pwr_avg_pkg::AVG_TABLE[a]));
            check(40'(n_bus), 40'(pwr_avg_pkg::AVG_TABLE[a]));
        end
    endtask
    task automatic t_zero_cal_shunt_only();
        cal <= 16'h0000;
        wcfg(pwr_avg_pkg::MODE_SINGLE, 3'h1, 1'b0);
        wait_res(1'b0);
        cal <= 16'h1000;
        wcfg(pwr_avg_pkg::MODE_SINGLE, 3'h1, 1'b1);
        wait_res(1'b1);
        check(40'(n_bus), 40'h0);
    endtask
    task automatic t_single_cont();
        repeat (60) @(posedge clk);
        check(40'(n_sh), 40'h4);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(40'(flag), 40'h0);
        wcfg(pwr_avg_pkg::MODE_CONT, 3'h0, 1'b0);
        repeat (200) @(posedge clk);
        check(40'(n_sh > 8), 40'h1);
        check(40'(flag), 40'h1);
        wcfg(pwr_avg_pkg::MODE_OFF, 3'h0, 1'b0);
        repeat (20) @(posedge clk);
        n_sh = 0;
        repeat (40) @(posedge clk);
        check(40'(n_sh), 40'h0);
        check(40'(flag), 40'h1);
    endtask
    // a frozen core ignores a write and a read, then wakes and runs a set
    task automatic t_ce_hold();
        ce <= 1'b0;
        @(posedge clk);
        wcfg(pwr_avg_pkg::MODE_SINGLE, 3'h0, 1'b0);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        ce <= 1'b1;
        repeat (20) @(posedge clk);
        check(40'(n_sh), 40'h0);
        check(40'(flag), 40'h1);
        wcfg(pwr_avg_pkg::MODE_SINGLE, 3'h0, 1'b0);
        wait_res(1'b0);
        check(40'(n_bus), 40'h1);
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_avg_all();
        t_zero_cal_shunt_only();
        t_single_cont();
        t_ce_hold();
        print_verdict();
    end
endmodule
bind pwr_avg_seq pwr_avg_sva chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cfg(i_cfg),
    .i_cfg_wr(i_cfg_wr), .i_cal(i_cal), .i_mask_rd(i_mask_rd), .i_adc_done(i_adc_done),
    .i_adc_data(i_adc_data), .o_adc_req(o_adc_req), .o_result(o_result),
    .o_conversion_ready_flag(o_conversion_ready_flag));
